/* hdl/wwdt_cnt.sv */
// Up counter with clear and increment enable, used for the window and the reset delay
`timescale 1ns/10ps
module wwdt_cnt
  import wwdt_pkg::*;
#(
  parameter int unsigned CNT_W = CNT_W_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic clr,
  input wire logic inc,
  // Count
  output logic [CNT_W-1:0] cnt_r
);

  logic [CNT_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (clr) begin
      cnt_nxt = '0;
    end else if (inc) begin
      cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

/* hdl/wwdt_pkg.sv */
// Shared constants and types of the window watchdog
package wwdt_pkg;

  // ==========================================================
  // Clock and time base
  localparam int unsigned CLK_FREQ_HZ = 25_000_000;
  localparam int unsigned HZ_PER_MHZ = 1_000_000;
  localparam int unsigned CYC_PER_US = CLK_FREQ_HZ / HZ_PER_MHZ;
  localparam int unsigned CNT_W_DEF = 32;

  // ==========================================================
  // Default times in microseconds
  localparam int unsigned TOUT_GND_US_DEF = 10_000;
  localparam int unsigned TOUT_VDD_US_DEF = 100_000;
  localparam int unsigned TOUT_NC_US_DEF = 1_000_000;
  localparam int unsigned RST_DELAY_US_DEF = 200_000;

  // ==========================================================
  // Selection encodings
  localparam logic [1:0] SEL_RATIO_1_8 = 2'h0;
  localparam logic [1:0] SEL_RATIO_1_2 = 2'h1;
  localparam logic [1:0] SEL_DISABLED = 2'h2;
  localparam logic [1:0] SEL_RATIO_3_4 = 2'h3;
  localparam logic [1:0] TSP_GND = 2'h0;
  localparam logic [1:0] TSP_VDD = 2'h1;
  localparam int unsigned SHIFT_EIGHTH = 3;
  localparam int unsigned SHIFT_HALF = 1;
  localparam int unsigned SHIFT_QUARTER = 2;

  // ==========================================================
  // Reset values
  localparam logic KICK_PREV_RST = 1'b0;
  localparam logic FAULT_OE_RST = 1'b0;
  localparam logic FAULT_DO_VAL = 1'b0;

  typedef enum logic [1:0] {
    ST_PWRUP,
    ST_RUN,
    ST_FAULT,
    ST_DIS
  } wwdt_state_e;

endpackage

/* hdl/wwdt_top.sv */
// Window watchdog: kick window check and fault reset output
//
// Overview of operation
// - Timeout pulls fault output low for delay
// - Power-up ignores kicks until delay expires
// - Kicks ignored while fault output is low
// - Disabled: output released, kicks fully ignored
// - Selects and timeout pin choose ratio, period
`timescale 1ns/10ps
module wwdt_top
  import wwdt_pkg::*;
#(
  parameter int unsigned CNT_W = CNT_W_DEF,
  parameter int unsigned TOUT_GND_US = TOUT_GND_US_DEF,
  parameter int unsigned TOUT_VDD_US = TOUT_VDD_US_DEF,
  parameter int unsigned TOUT_NC_US = TOUT_NC_US_DEF,
  parameter int unsigned RST_DELAY_US = RST_DELAY_US_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Watchdog kick from the host
  input wire logic kick_input,
  // Configuration straps
  input wire logic window_select_0,
  input wire logic window_select_1,
  input wire logic [1:0] timeout_setting_pin,
  // Open-drain fault output, low while in fault
  output logic fault_reset_output_n_do_r,
  output logic fault_reset_output_n_oe_r
);

  // ==========================================================
  // Derived cycle counts
  localparam longint unsigned TOUT_GND_CYC = longint'(TOUT_GND_US) * CYC_PER_US;
  localparam longint unsigned TOUT_VDD_CYC = longint'(TOUT_VDD_US) * CYC_PER_US;
  localparam longint unsigned TOUT_NC_CYC = longint'(TOUT_NC_US) * CYC_PER_US;
  localparam longint unsigned RST_CYC = longint'(RST_DELAY_US) * CYC_PER_US;
  localparam longint unsigned CNT_LIM = longint'(1) << CNT_W;

  if (CNT_W < 4 || CNT_W > 40 || TOUT_GND_CYC < 8 || TOUT_VDD_CYC < 8 ||
      TOUT_NC_CYC < 8 || RST_CYC < 1 || TOUT_GND_CYC >= CNT_LIM ||
      TOUT_VDD_CYC >= CNT_LIM || TOUT_NC_CYC >= CNT_LIM || RST_CYC >= CNT_LIM) begin : g_bad
    $error("wwdt_top: counts do not fit the counter width");
  end

  localparam logic [CNT_W-1:0] TOUT_GND_M1 = CNT_W'(TOUT_GND_CYC - 1);
  localparam logic [CNT_W-1:0] TOUT_VDD_M1 = CNT_W'(TOUT_VDD_CYC - 1);
  localparam logic [CNT_W-1:0] TOUT_NC_M1 = CNT_W'(TOUT_NC_CYC - 1);
  localparam logic [CNT_W-1:0] RST_M1 = CNT_W'(RST_CYC - 1);

  wwdt_state_e st_r;
  wwdt_state_e st_nxt;
  logic kick_prev_r;
  logic kick_fall;
  logic enabled;
  logic [1:0] sel;
  logic [CNT_W-1:0] upper_m1;
  logic [CNT_W-1:0] upper;
  logic [CNT_W-1:0] lower;
  logic [CNT_W-1:0] win_cnt;
  logic [CNT_W-1:0] dly_cnt;
  logic win_clr;
  logic win_inc;
  logic dly_clr;
  logic dly_inc;
  logic oe_nxt;

  // ==========================================================
  // Configuration decode
  assign sel = {window_select_1, window_select_0};
  assign enabled = (sel != SEL_DISABLED);
  assign kick_fall = kick_prev_r & ~kick_input;

  always_comb begin
    case (timeout_setting_pin)
      TSP_GND: upper_m1 = TOUT_GND_M1;
      TSP_VDD: upper_m1 = TOUT_VDD_M1;
      default: upper_m1 = TOUT_NC_M1;
    endcase
    upper = upper_m1 + {{(CNT_W-1){1'b0}}, 1'b1};
    case (sel)
      SEL_RATIO_1_8: lower = upper >> SHIFT_EIGHTH;
      SEL_RATIO_1_2: lower = upper >> SHIFT_HALF;
      SEL_RATIO_3_4: lower = upper - (upper >> SHIFT_QUARTER);
      default: lower = '0;
    endcase
  end

  // ==========================================================
  // Counters
  wwdt_cnt #(.CNT_W(CNT_W)) u_win_cnt (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(win_clr),
    .inc(win_inc),
    .cnt_r(win_cnt)
  );

  wwdt_cnt #(.CNT_W(CNT_W)) u_dly_cnt (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(dly_clr),
    .inc(dly_inc),
    .cnt_r(dly_cnt)
  );

  // ==========================================================
  // Sequencer
  always_comb begin
    st_nxt = st_r;
    win_clr = 1'b0;
    win_inc = 1'b0;
    dly_clr = 1'b0;
    dly_inc = 1'b0;
    case (st_r)
      ST_PWRUP: begin
        dly_inc = 1'b1;
        if (dly_cnt >= RST_M1) begin
          st_nxt = ST_RUN;
          win_clr = 1'b1;
        end
      end
      ST_RUN: begin
        win_inc = 1'b1;
        if (!enabled) begin
          st_nxt = ST_DIS;
        end else if (kick_fall && win_cnt < lower) begin
          st_nxt = ST_FAULT;
          dly_clr = 1'b1;
        end else if (kick_fall) begin
          win_clr = 1'b1;
        end else if (win_cnt >= upper_m1) begin
          st_nxt = ST_FAULT;
          dly_clr = 1'b1;
        end
      end
      ST_FAULT: begin
        dly_inc = 1'b1;
        if (!enabled) begin
          st_nxt = ST_DIS;
        end else if (dly_cnt >= RST_M1) begin
          st_nxt = ST_RUN;
          win_clr = 1'b1;
        end
      end
      ST_DIS: begin
        if (enabled) begin
          st_nxt = ST_RUN;
          win_clr = 1'b1;
        end
      end
      default: begin
        st_nxt = ST_PWRUP;
        dly_clr = 1'b1;
      end
    endcase
    oe_nxt = (st_nxt == ST_FAULT);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= ST_PWRUP;
      kick_prev_r <= KICK_PREV_RST;
      fault_reset_output_n_oe_r <= FAULT_OE_RST;
      fault_reset_output_n_do_r <= FAULT_DO_VAL;
    end else begin
      st_r <= st_nxt;
      kick_prev_r <= kick_input;
      fault_reset_output_n_oe_r <= oe_nxt;
      fault_reset_output_n_do_r <= FAULT_DO_VAL;
    end
  end

  // ==========================================================
  // Assertions
  AST_TIMEOUT_FAULT: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_RUN && enabled && !kick_fall && win_cnt >= upper_m1)
      |=> fault_reset_output_n_oe_r && dly_cnt == '0)
    else $error("timeout did not assert fault output");

  AST_FAULT_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_FAULT && enabled && dly_cnt < RST_M1) |=> fault_reset_output_n_oe_r)
    else $error("fault output released before reset delay");

  AST_PWRUP_QUIET: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_PWRUP && dly_cnt < RST_M1) |=> !fault_reset_output_n_oe_r && st_r == ST_PWRUP)
    else $error("power-up left early or faulted");

  AST_FAULT_IGNORES_KICK: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_FAULT && enabled && kick_fall && dly_cnt < RST_M1)
      |=> st_r == ST_FAULT && dly_cnt == $past(dly_cnt) + 1'b1)
    else $error("kick disturbed fault delay");

  AST_DISABLED_RELEASED: assert property (@(posedge clk) disable iff (sys_rst)
    (!enabled && st_r != ST_PWRUP) ##1 !enabled |-> !fault_reset_output_n_oe_r && st_r == ST_DIS)
    else $error("disabled watchdog drives fault output");

  AST_GOOD_KICK: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_RUN && enabled && kick_fall && win_cnt >= lower)
      |=> st_r == ST_RUN && win_cnt == '0 && !fault_reset_output_n_oe_r)
    else $error("in-window kick not accepted");

  AST_EARLY_KICK: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_RUN && enabled && kick_fall && win_cnt < lower)
      |=> fault_reset_output_n_oe_r ##1 fault_reset_output_n_oe_r || !enabled)
    else $error("early kick did not fault");

  COV_TIMEOUT: cover property (@(posedge clk) disable iff (sys_rst)
    st_r == ST_RUN && !kick_fall && win_cnt >= upper_m1 && enabled);
  COV_GOOD_KICK: cover property (@(posedge clk) disable iff (sys_rst)
    st_r == ST_RUN && enabled && kick_fall && win_cnt >= lower);
  COV_EARLY_KICK: cover property (@(posedge clk) disable iff (sys_rst)
    st_r == ST_RUN && enabled && kick_fall && win_cnt < lower);
  COV_DISABLE: cover property (@(posedge clk) disable iff (sys_rst) st_r == ST_DIS);

endmodule

/* verif/wwdt_host_model.sv */
// Host model that pulses the watchdog kick line on command
`timescale 1ns/10ps
module wwdt_host_model (
  // Clock
  input wire logic clk,
  // Command from the bench
  input wire logic fire,
  // Kick line
  output logic kick_input
);
  logic req_r;
  initial begin
    req_r = 1'b0;
    kick_input = 1'b1;
  end
  always @(posedge clk) req_r <= fire;
  always @(negedge clk) kick_input <= ~req_r;
endmodule

/* verif/wwdt_top_bench.sv */
// Self-checking bench of the window watchdog
`timescale 1ns/10ps
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: %s", $time, m); end end
module wwdt_top_bench;
  import wwdt_pkg::*;
  // ==========================================================
  // Setup: short times keep the run small
  localparam int RC = 25;
  localparam int UT[4] = '{100, 200, 50, 50};
  localparam int LW[4] = '{12, 50, 0, 75};
  logic clk, sys_rst, fire, kick_input, sel0, sel1, oe, do_r;
  logic [1:0] tsp;
  int n_mismatch, compares, cyc, hi;
  wwdt_top #(.TOUT_GND_US(4), .TOUT_VDD_US(8), .TOUT_NC_US(2), .RST_DELAY_US(1)) DUT (
    .clk(clk), .sys_rst(sys_rst), .kick_input(kick_input),
    .window_select_0(sel0), .window_select_1(sel1), .timeout_setting_pin(tsp),
    .fault_reset_output_n_do_r(do_r), .fault_reset_output_n_oe_r(oe));
  wwdt_host_model host (.clk(clk), .fire(fire), .kick_input(kick_input));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========================================================
  // Shared tasks
  task automatic fault_sync(input bit kick_mid);
    int n;
    n = 0;
    hi = 0;
    while (oe !== 1'b1 && n < 2000) begin @(negedge clk); n++; end
    while (oe === 1'b1 && n < 2000) begin
      fire = kick_mid && (hi == 3);
      @(negedge clk);
      n++;
      hi++;
    end
    fire = 1'b0;
    `CHK(n < 2000, 1'b1, "no fault seen")
  endtask
  // Counts from the cycle after a fault ends until the next fault
  task automatic window(input int kick, input int exp, input string m);
    int n;
    n = 0;
    while (oe !== 1'b1 && n < 500) begin
      fire = (n == kick - 1);
      @(negedge clk);
      n++;
    end
    fire = 1'b0;
    `CHK(n, exp, m)
  endtask
  task automatic set_sel(input logic [1:0] s);
    {sel1, sel0} = s;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_powerup;
    int n;
    for (n = 0; n < RC + 20; n++) begin
      fire = (n == 3 || n == 18);
      @(negedge clk);
      `CHK(oe, 1'b0, "early fault in power-up")
    end
    fire = 1'b0;
    while (oe !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    `CHK(n, RC + UT[0], "power-up length")
    fault_sync(1'b0);
    `CHK(hi, RC, "first fault length")
    `CHK(do_r, 1'b0, "pin data not low")
    $display("test powerup done");
  endtask
  task automatic t_timeout;
    for (int t = 0; t < 4; t++) begin
      tsp = t[1:0];
      window(-1, UT[t], "timeout period");
      fault_sync(1'b0);
      `CHK(hi, RC, "fault length")
    end
    tsp = TSP_GND;
    $display("test timeout done");
  endtask
  task automatic t_windows;
    logic [1:0] s[3] = '{SEL_RATIO_1_8, SEL_RATIO_1_2, SEL_RATIO_3_4};
    int lw;
    for (int i = 0; i < 3; i++) begin
      set_sel(s[i]);
      lw = LW[s[i]];
      window(lw, lw + 1 + 100, "kick at lower bound");
      fault_sync(1'b0);
      window(lw - 1, lw, "early kick");
      fault_sync(1'b0);
    end
    window(99, 200, "kick at upper bound");
    fault_sync(1'b1);
    `CHK(hi, RC, "kick during fault")
    set_sel(SEL_RATIO_1_8);
    $display("test windows done");
  endtask
  task automatic t_disable;
    window(-1, UT[0], "timeout before disable");
    set_sel(SEL_DISABLED);
    @(negedge clk);
    `CHK(oe, 1'b0, "fault kept when disabled")
    for (int n = 0; n < 300; n++) begin
      fire = (n % 7 == 0);
      @(negedge clk);
      `CHK(oe, 1'b0, "fault while disabled")
    end
    fire = 1'b0;
    set_sel(SEL_RATIO_1_8);
    // Select changes before the edge that restarts the window
    window(-1, UT[0] + 1, "window after enable");
    fault_sync(1'b0);
    `CHK(hi, RC, "fault after enable")
    $display("test disable done");
  endtask
  // Reset in mid-fault: output released, full power-up again
  task automatic t_rerun;
    int n;
    window(-1, UT[0], "timeout before reset");
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(oe, 1'b0, "fault kept in reset")
    sys_rst = 1'b0;
    n = 0;
    while (oe !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    `CHK(n, RC + UT[0], "power-up after reset")
    fault_sync(1'b0);
    `CHK(hi, RC, "fault after reset")
    $display("test rerun done");
  endtask
  // ==========================================================
  // Closing and hang guard
  task automatic test_done;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done;
    end
  end
  initial begin
    sys_rst = 1'b1;
    fire = 1'b0;
    sel0 = 1'b0;
    sel1 = 1'b0;
    tsp = TSP_GND;
    n_mismatch = 0;
    compares = 0;
    cyc = 0;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    t_powerup;
    t_timeout;
    t_windows;
    t_disable;
    t_rerun;
    test_done;
  end
endmodule
